// file: rtl/gpio_seq_pkg.sv
// Purpose: Shared constants for the pin and scan register bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Byte address is four times the register index
`default_nettype none
package gpio_seq_pkg;

  // ==========================================================
  // Sizes
  localparam int CHANNELS = 8;
  localparam int CH_W     = 3;
  localparam int ADDR_W   = 8;
  localparam int IDX_W    = 6;
  localparam int REG_W    = 8;

  // ==========================================================
  // Register indices
  localparam logic [IDX_W-1:0] IDX_PIN_FUNCTION      = 6'h05;
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION     = 6'h07;
  localparam logic [IDX_W-1:0] IDX_OUTPUT_DRIVE_TYPE = 6'h09;
  localparam logic [IDX_W-1:0] IDX_OUTPUT_LEVEL      = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_INPUT_LEVEL       = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_SCAN_CONTROL      = 6'h10;
  localparam logic [IDX_W-1:0] IDX_MANUAL_CH_SELECT  = 6'h11;
  localparam logic [IDX_W-1:0] IDX_SCAN_ENABLE_MASK  = 6'h12;
  localparam logic [IDX_W-1:0] IDX_ALERT_CH_MASK     = 6'h14;

  // ==========================================================
  // Reset values and writable bits
  localparam logic [REG_W-1:0] REG_RESET       = 8'h00;
  localparam logic [REG_W-1:0] SCAN_CTRL_WMASK = 8'h13;
  localparam logic [REG_W-1:0] CH_SEL_WMASK    = 8'h0f;

  // ==========================================================
  // Field positions
  localparam int SEQUENCE_START_BIT_BIT = 4;
  localparam int MODE_MSB      = 1;
  localparam int MODE_LSB      = 0;
  localparam int MANUAL_MSB    = 3;
  localparam int MANUAL_RSV    = 3;

  // ==========================================================
  // Scan modes
  typedef enum logic [1:0]
  {
    MODE_MANUAL = 2'h0,
    MODE_AUTO   = 2'h1,
    MODE_RSV_2  = 2'h2,
    MODE_RSV_3  = 2'h3
  } scan_mode_e;

endpackage
`default_nettype wire

// file: rtl/pin_cell.sv
// Purpose: One general-purpose pin: driver control and input sampling
// Assumes: pad_in is asynchronous to pclk
// Notes:   Driver outputs are registered
`timescale 1ns/100ps
`default_nettype none
module pin_cell
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Configuration
  input  wire logic is_gpio,
  input  wire logic is_output,
  input  wire logic push_pull,
  input  wire logic level,
  // Pad
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      level_sync
);

  logic sync_first;
  logic drive_on;

  // ==========================================================
  // Driver
  assign drive_on = is_gpio & is_output;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end
    else
    begin
      pad_out <= drive_on & level;
      pad_oe  <= drive_on & (push_pull | ~level);
    end
  end

  // ==========================================================
  // Input synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_first <= 1'b0;
      level_sync <= 1'b0;
    end
    else
    begin
      sync_first <= pad_in;
      level_sync <= sync_first;
    end
  end

endmodule
`default_nettype wire

// file: rtl/channel_sequencer.sv
// Purpose: Ascending scan over the enabled channels
// Assumes: step comes from the conversion engine on pclk
// Notes:   Wraps from the highest enabled channel to the lowest
`timescale 1ns/100ps
`default_nettype none
module channel_sequencer #(
  parameter int N    = 8,
  parameter int CH_W = 3
)
(
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Control
  input  wire logic            run,
  input  wire logic [N-1:0]    mask,
  input  wire logic            step,
  // Status
  output logic [CH_W-1:0]      channel,
  output logic                 busy,
  output logic                 have_channel
);

  typedef enum logic
  {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_e;

  seq_state_e state;

  // ==========================================================
  // Next enabled channel above cur, wrapping
  function automatic logic [CH_W-1:0] next_after(input logic [CH_W-1:0] cur,
                                                 input logic [N-1:0] m);
    int idx;
    logic found;
    next_after = cur;
    found = 1'b0;
    for (int i = 1; i <= N; i++)
    begin
      idx = (int'(cur) + i) % N;
      if (!found && m[idx])
      begin
        next_after = CH_W'(idx);
        found = 1'b1;
      end
    end
  endfunction

  // ==========================================================
  // State and channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state   <= SEQ_IDLE;
      channel <= '0;
    end
    else
    begin
      unique case (state)
        SEQ_IDLE:
        begin
          if (run)
          begin
            state   <= SEQ_RUN;
            channel <= next_after(CH_W'(N - 1), mask);
          end
        end
        SEQ_RUN:
        begin
          if (!run)
            state <= SEQ_IDLE;
          else if (step || !mask[channel])
            channel <= next_after(channel, mask);
        end
      endcase
    end
  end

  assign busy         = (state == SEQ_RUN);
  assign have_channel = busy & mask[channel];

endmodule
`default_nettype wire

// file: rtl/gpio_and_channel_sequencer_regs.sv
// Purpose: Pin configuration and scan selection registers on APB
// Assumes: One pclk domain; pad inputs are asynchronous
// Notes:   Zero-wait-state slave; read data latched in setup phase
`timescale 1ns/100ps
`default_nettype none
module gpio_and_channel_sequencer_regs #(
  parameter int N = 8
)
(
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [gpio_seq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Pads
  input  wire logic [N-1:0]                    pad_in,
  output logic [N-1:0]                         pad_out,
  output logic [N-1:0]                         pad_oe,
  // Conversion engine
  input  wire logic                            conv_done,
  output logic [3:0]                           conv_channel,
  output logic                                 conv_channel_valid,
  output logic                                 scan_running,
  output logic [N-1:0]                         analog_enable,
  output logic [N-1:0]                         alert_channel_mask
);

  // ==========================================================
  // Register storage
  logic [N-1:0] pin_function;
  logic [N-1:0] pin_direction;
  logic [N-1:0] output_drive_type;
  logic [N-1:0] output_level;
  logic [N-1:0] input_level;
  logic [N-1:0] scan_enable_mask;
  logic         sequence_start_bit;
  logic [1:0]   scan_mode_field;
  logic [3:0]   manual_channel_field;

  // ==========================================================
  // Bus decode
  logic [gpio_seq_pkg::IDX_W-1:0] idx;
  logic                           hit;
  logic                           aligned;
  logic                           wr_en;
  logic [7:0]                     wbyte;
  logic [31:0]                    next_prdata;

  // ==========================================================
  // Scan internals
  logic [gpio_seq_pkg::CH_W-1:0] seq_channel;
  logic                          seq_busy;
  logic                          seq_have;
  logic                          auto_run;
  logic                          manual_ok;
  logic [N-1:0]                  level_sync;

  assign idx     = paddr[gpio_seq_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wbyte   = pwdata[7:0];

  always_comb
  begin
    unique case (idx)
      gpio_seq_pkg::IDX_PIN_FUNCTION,
      gpio_seq_pkg::IDX_PIN_DIRECTION,
      gpio_seq_pkg::IDX_OUTPUT_DRIVE_TYPE,
      gpio_seq_pkg::IDX_OUTPUT_LEVEL,
      gpio_seq_pkg::IDX_INPUT_LEVEL,
      gpio_seq_pkg::IDX_SCAN_CONTROL,
      gpio_seq_pkg::IDX_MANUAL_CH_SELECT,
      gpio_seq_pkg::IDX_SCAN_ENABLE_MASK,
      gpio_seq_pkg::IDX_ALERT_CH_MASK:
        hit = aligned;
      default:
        hit = 1'b0;
    endcase
  end

  // ==========================================================
  // APB handshake
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit & pstrb[0];

  // ==========================================================
  // Read mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit)
    begin
      unique case (idx)
        gpio_seq_pkg::IDX_PIN_FUNCTION:
          next_prdata[N-1:0] = pin_function;
        gpio_seq_pkg::IDX_PIN_DIRECTION:
          next_prdata[N-1:0] = pin_direction;
        gpio_seq_pkg::IDX_OUTPUT_DRIVE_TYPE:
          next_prdata[N-1:0] = output_drive_type;
        gpio_seq_pkg::IDX_OUTPUT_LEVEL:
          next_prdata[N-1:0] = output_level;
        gpio_seq_pkg::IDX_INPUT_LEVEL:
          next_prdata[N-1:0] = input_level;
        gpio_seq_pkg::IDX_SCAN_CONTROL:
        begin
          next_prdata[gpio_seq_pkg::SEQUENCE_START_BIT_BIT] = sequence_start_bit;
          next_prdata[gpio_seq_pkg::MODE_MSB:gpio_seq_pkg::MODE_LSB] = scan_mode_field;
        end
        gpio_seq_pkg::IDX_MANUAL_CH_SELECT:
          next_prdata[gpio_seq_pkg::MANUAL_MSB:0] = manual_channel_field;
        gpio_seq_pkg::IDX_SCAN_ENABLE_MASK:
          next_prdata[N-1:0] = scan_enable_mask;
        gpio_seq_pkg::IDX_ALERT_CH_MASK:
          next_prdata[N-1:0] = alert_channel_mask;
        default:
          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  // ==========================================================
  // Pin configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_function  <= N'(gpio_seq_pkg::REG_RESET);
      pin_direction <= N'(gpio_seq_pkg::REG_RESET);
    end
    else if (wr_en)
    begin
      if (idx == gpio_seq_pkg::IDX_PIN_FUNCTION)
        pin_function <= wbyte[N-1:0];
      if (idx == gpio_seq_pkg::IDX_PIN_DIRECTION)
        pin_direction <= wbyte[N-1:0];
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_drive_type <= N'(gpio_seq_pkg::REG_RESET);
      output_level      <= N'(gpio_seq_pkg::REG_RESET);
    end
    else if (wr_en)
    begin
      if (idx == gpio_seq_pkg::IDX_OUTPUT_DRIVE_TYPE)
        output_drive_type <= wbyte[N-1:0];
      if (idx == gpio_seq_pkg::IDX_OUTPUT_LEVEL)
        output_level <= wbyte[N-1:0];
    end
  end

  // ==========================================================
  // Input level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      input_level <= N'(gpio_seq_pkg::REG_RESET);
    else
      input_level <= level_sync;
  end

  // ==========================================================
  // Scan control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sequence_start_bit   <= 1'b0;
      scan_mode_field      <= gpio_seq_pkg::MODE_MANUAL;
      manual_channel_field <= 4'h0;
    end
    else if (wr_en)
    begin
      if (idx == gpio_seq_pkg::IDX_SCAN_CONTROL)
      begin
        sequence_start_bit <= wbyte[gpio_seq_pkg::SEQUENCE_START_BIT_BIT];
        scan_mode_field    <=
          wbyte[gpio_seq_pkg::MODE_MSB:gpio_seq_pkg::MODE_LSB];
      end
      if (idx == gpio_seq_pkg::IDX_MANUAL_CH_SELECT)
        manual_channel_field <= wbyte[gpio_seq_pkg::MANUAL_MSB:0];
    end
  end

  // ==========================================================
  // Mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_enable_mask   <= N'(gpio_seq_pkg::REG_RESET);
      alert_channel_mask <= N'(gpio_seq_pkg::REG_RESET);
    end
    else if (wr_en)
    begin
      if (idx == gpio_seq_pkg::IDX_SCAN_ENABLE_MASK)
        scan_enable_mask <= wbyte[N-1:0];
      if (idx == gpio_seq_pkg::IDX_ALERT_CH_MASK)
        alert_channel_mask <= wbyte[N-1:0];
    end
  end

  // ==========================================================
  // Pins
  for (genvar g = 0; g < N; g++)
  begin : g_pin
    pin_cell u_pin
    (
      .pclk       (pclk),
      .presetn    (presetn),
      .is_gpio    (pin_function[g]),
      .is_output  (pin_direction[g]),
      .push_pull  (output_drive_type[g]),
      .level      (output_level[g]),
      .pad_in     (pad_in[g]),
      .pad_out    (pad_out[g]),
      .pad_oe     (pad_oe[g]),
      .level_sync (level_sync[g])
    );
  end

  // ==========================================================
  // Sequencer
  assign auto_run = sequence_start_bit &
                    (scan_mode_field == gpio_seq_pkg::MODE_AUTO);

  channel_sequencer #(
    .N    (N),
    .CH_W (gpio_seq_pkg::CH_W)
  ) u_seq
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (auto_run),
    .mask         (scan_enable_mask & ~pin_function),
    .step         (conv_done),
    .channel      (seq_channel),
    .busy         (seq_busy),
    .have_channel (seq_have)
  );

  // ==========================================================
  // Channel selection
  assign manual_ok = ~manual_channel_field[gpio_seq_pkg::MANUAL_RSV] &
                     ~pin_function[manual_channel_field[gpio_seq_pkg::CH_W-1:0]];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_channel       <= 4'h0;
      conv_channel_valid <= 1'b0;
      scan_running       <= 1'b0;
      analog_enable      <= N'(gpio_seq_pkg::REG_RESET);
    end
    else
    begin
      analog_enable <= ~pin_function;
      scan_running  <= seq_busy;
      unique case (scan_mode_field)
        gpio_seq_pkg::MODE_MANUAL:
        begin
          conv_channel       <= manual_channel_field;
          conv_channel_valid <= manual_ok;
        end
        gpio_seq_pkg::MODE_AUTO:
        begin
          conv_channel       <= {1'b0, seq_channel};
          conv_channel_valid <= seq_have;
        end
        default:
        begin
          conv_channel       <= 4'h0;
          conv_channel_valid <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: tb/gpio_seq_properties.sv
// Purpose: Port-level properties of the pin and scan register bank
// Assumes: One pclk domain, zero-wait APB slave
// Notes:   Bound to the top module after endmodule
`timescale 1ns/100ps
`default_nettype none
module gpio_seq_properties #(
  parameter int N = 8
)
(
  // Clock and reset
  input wire logic                            pclk,
  input wire logic                            presetn,
  // APB
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [gpio_seq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic [3:0]                      pstrb,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  // Pads and engine
  input wire logic [N-1:0]                    pad_in,
  input wire logic [N-1:0]                    pad_out,
  input wire logic [N-1:0]                    pad_oe,
  input wire logic                            conv_done,
  input wire logic [3:0]                      conv_channel,
  input wire logic                            conv_channel_valid,
  input wire logic                            scan_running,
  input wire logic [N-1:0]                    analog_enable,
  input wire logic [N-1:0]                    alert_channel_mask
);
  // ==========================================================
  // Helpers
  localparam logic [7:0] A_SC   = {gpio_seq_pkg::IDX_SCAN_CONTROL, 2'b00};
  localparam logic [7:0] A_SEL  = {gpio_seq_pkg::IDX_MANUAL_CH_SELECT, 2'b00};
  localparam logic [7:0] A_IN   = {gpio_seq_pkg::IDX_INPUT_LEVEL, 2'b00};
  localparam logic [7:0] A_FUNC = {gpio_seq_pkg::IDX_PIN_FUNCTION, 2'b00};
  logic acc_rd;
  logic acc_wr;
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite && pstrb[0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Properties
  a_oe_gpio_only: assert property ((pad_oe & analog_enable) == '0)
    else $error("Pad driven on an analog channel");
  a_out_gpio_only: assert property ((pad_out & analog_enable) == '0)
    else $error("Pad level set on an analog channel");
  a_ctrl_rsv_zero: assert property (acc_rd && paddr == A_SC
    |-> (prdata & 32'hffff_ffec) == 0)
    else $error("Scan control reserved bits not zero");
  a_sel_rsv_zero: assert property (acc_rd && paddr == A_SEL |-> prdata[31:4] == 0)
    else $error("Channel select reserved bits not zero");
  a_input_no_error: assert property (psel && penable && paddr == A_IN |-> !pslverr)
    else $error("Input level access flagged as error");
  a_scan_starts: assert property (acc_wr && paddr == A_SC && pwdata[4]
    && pwdata[1:0] == 2'b01 |-> ##[1:3] scan_running)
    else $error("Sequencer did not start");
  a_scan_stops: assert property (acc_wr && paddr == A_SC && !pwdata[4]
    |-> ##[1:3] !scan_running)
    else $error("Sequencer did not stop");
  a_manual_range: assert property (conv_channel_valid |-> !conv_channel[3])
    else $error("Reserved channel code marked valid");
  a_func_to_analog: assert property (acc_wr && paddr == A_FUNC
    |-> ##2 analog_enable == ~$past(pwdata[N-1:0], 2))
    else $error("Analog enable does not follow pin function");
  a_reset_clear: assert property ($rose(presetn)
    |-> pad_oe == 0 && pad_out == 0 && !scan_running && alert_channel_mask == 0)
    else $error("Outputs not cleared by reset");
endmodule

bind gpio_and_channel_sequencer_regs gpio_seq_properties #(.N(N)) i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .pad_in, .pad_out, .pad_oe, .conv_done, .conv_channel, .conv_channel_valid,
  .scan_running, .analog_enable, .alert_channel_mask);
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the pin and scan register bank
// Assumes: Zero-wait APB slave, byte address four times the index
// Notes:   Each scenario is its own task
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pad_in;
  logic [7:0]  pad_out;
  logic [7:0]  pad_oe;
  logic        conv_done;
  logic [3:0]  conv_channel;
  logic        conv_channel_valid;
  logic        scan_running;
  logic [7:0]  analog_enable;
  logic [7:0]  alert_channel_mask;
  logic [31:0] rd;
  logic        err;
  logic [1:0]  addr_low;
  int          mismatches;
  int          total_checks;

  gpio_and_channel_sequencer_regs #(.N(8)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pad_in, .pad_out, .pad_oe, .conv_done, .conv_channel, .conv_channel_valid,
    .scan_running, .analog_enable, .alert_channel_mask);

  always #20 pclk = ~pclk;

  // ==========================================================
  // Shared tasks
  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ba(idx) | 8'(addr_low);
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        mismatches++;
        $display("ERROR %0t: no pready", $time);
        final_report();
      end
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic pulse_done();
    @(posedge pclk);
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    logic [5:0] regs [9];
    regs = '{6'h05, 6'h07, 6'h09, 6'h0b, 6'h0d, 6'h10, 6'h11, 6'h12, 6'h14};
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 0);
      check(rd, 0, "reset value");
    end
    check(pad_oe, 0, "reset pad_oe");
    $display("test_reset done");
  endtask

  task automatic test_regs();
    logic [5:0] rw [4];
    rw = '{6'h09, 6'h0b, 6'h12, 6'h14};
    foreach (rw[i])
    begin
      apb(1'b1, rw[i], 32'h0000_00a5);
      apb(1'b0, rw[i], 0);
      check(rd, 32'h0000_00a5, "readback");
    end
    check(alert_channel_mask, 8'ha5, "alert mask port");
    apb(1'b1, 6'h10, 32'hffff_ffff);
    apb(1'b0, 6'h10, 0);
    check(rd, 32'h0000_0013, "scan control reserved");
    apb(1'b1, 6'h11, 32'hffff_ffff);
    apb(1'b0, 6'h11, 0);
    check(rd, 32'h0000_000f, "channel select reserved");
    apb(1'b1, 6'h0d, 32'h0000_00ff);
    check(err, 1'b0, "input level write error");
    apb(1'b0, 6'h0d, 0);
    check(rd, 0, "input level write ignored");
    apb(1'b0, 6'h01, 0);
    check({rd[30:0], err}, 1, "unmapped read");
    foreach (rw[i]) apb(1'b1, rw[i], 0);
    apb(1'b1, 6'h10, 0);
    apb(1'b1, 6'h11, 0);
    addr_low = 2'h1;
    apb(1'b1, 6'h12, 32'h0000_00ff);
    check(err, 1'b1, "unaligned write error");
    addr_low = 2'h0;
    pstrb <= 4'he;
    apb(1'b1, 6'h12, 32'h0000_00ff);
    pstrb <= 4'hf;
    apb(1'b0, 6'h12, 0);
    check(rd, 0, "refused writes stored");
    $display("test_regs done");
  endtask

  task automatic test_pins();
    apb(1'b1, 6'h05, 32'h0000_000f);
    apb(1'b1, 6'h07, 32'h0000_0003);
    apb(1'b1, 6'h09, 32'h0000_0001);
    apb(1'b1, 6'h0b, 32'h0000_0003);
    cycles(2);
    check({pad_oe, pad_out}, 16'h0103, "drive mixed");
    check(analog_enable, 8'hf0, "analog enable");
    apb(1'b1, 6'h0b, 0);
    cycles(2);
    check({pad_oe, pad_out}, 16'h0300, "drive low");
    apb(1'b1, 6'h09, 32'h0000_00ff);
    apb(1'b1, 6'h0b, 32'h0000_00ff);
    cycles(2);
    check({pad_oe, pad_out}, 16'h0303, "push-pull high");
    apb(1'b1, 6'h05, 0);
    cycles(2);
    check({pad_oe, pad_out, analog_enable}, 24'h0000ff, "analog pins");
    apb(1'b1, 6'h05, 32'h0000_00ff);
    apb(1'b1, 6'h07, 0);
    cycles(2);
    check({pad_oe, pad_out}, 0, "input pins");
    apb(1'b1, 6'h05, 0);
    apb(1'b1, 6'h09, 0);
    apb(1'b1, 6'h0b, 0);
    $display("test_pins done");
  endtask

  task automatic test_input();
    pad_in <= 8'h5a;
    cycles(4);
    apb(1'b0, 6'h0d, 0);
    check(rd, 32'h0000_005a, "input level");
    pad_in <= 8'ha5;
    cycles(4);
    apb(1'b0, 6'h0d, 0);
    check(rd, 32'h0000_00a5, "input level");
    $display("test_input done");
  endtask

  task automatic test_manual();
    for (int ch = 0; ch < 10; ch++)
    begin
      apb(1'b1, 6'h11, ch);
      cycles(3);
      check({conv_channel_valid, conv_channel}, {ch < 8, 4'(ch)}, "manual");
    end
    apb(1'b1, 6'h05, 32'h0000_0008);
    apb(1'b1, 6'h11, 3);
    cycles(3);
    check(conv_channel_valid, 0, "gpio channel");
    apb(1'b1, 6'h05, 0);
    apb(1'b1, 6'h11, 2);
    for (int m = 2; m < 4; m++)
    begin
      apb(1'b1, 6'h10, m);
      cycles(3);
      check({conv_channel_valid, conv_channel, scan_running}, 0, "reserved mode");
    end
    apb(1'b1, 6'h10, 0);
    $display("test_manual done");
  endtask

  task automatic test_auto();
    logic [3:0] exp [3];
    exp = '{4'd2, 4'd5, 4'd1};
    apb(1'b1, 6'h12, 32'h0000_0026);
    apb(1'b1, 6'h10, 32'h0000_0011);
    cycles(3);
    check({scan_running, conv_channel_valid, conv_channel}, 6'h31, "auto first");
    foreach (exp[i])
    begin
      pulse_done();
      cycles(3);
      check({conv_channel_valid, conv_channel}, {1'b1, exp[i]}, "auto step");
    end
    apb(1'b1, 6'h10, 32'h0000_0001);
    cycles(3);
    check(scan_running, 0, "auto stop");
    apb(1'b1, 6'h10, 0);
    apb(1'b1, 6'h12, 0);
    $display("test_auto done");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hf;
    addr_low = 0;
    pad_in = 0;
    conv_done = 0;
    mismatches = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_regs();
    test_pins();
    test_input();
    test_manual();
    test_auto();
    final_report();
  end
endmodule
`default_nettype wire
